// ===== servo_calib_cmd_readout_select.sv
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Switch bits: one is on, zero is off
// - Centre reference measured while its switch set
// - Focus input corrected by centre reference level
// - Focus zero level measured while switch set
// - Focus zero-cross compensated by focus zero
// - RF zero level measured while switch set
// - RF input compensated by RF zero
// - Focus auto gain runs while switch set
// - Tracking auto gain runs while switch set
// - Defect countermeasure off while disable is one
// - Sled free-run guard off while disable one
// - Traverse centre measured while switch set
// - Tracking zero level measured while switch set
// - Focus input compensated by focus zero level
// - Traverse centre compensation applied when set
// - Tracking zero compensation applied when set
// - Track/sled input corrected by centre reference
// - Measurement switches sampled once per interval
// - Select word: DAC mode and 7-bit selector
// - Coefficients 40h to 4Fh refuse readout
// - Traverse centre readout uses the same measured level register
module servo_calib_cmd_readout_select
    import servo_calib_pkg::*;
#(
    parameter int MEASURE_CYCLES_P = MEASURE_CYCLES
) (
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    input  wire logic [9:0]    s_axi_awaddr_i,
    input  wire logic          s_axi_awvalid_i,
    output logic               s_axi_awready_o,
    input  wire logic [31:0]   s_axi_wdata_i,
    input  wire logic [3:0]    s_axi_wstrb_i,
    input  wire logic          s_axi_wvalid_i,
    output logic               s_axi_wready_o,
    output logic [1:0]         s_axi_bresp_o,
    output logic               s_axi_bvalid_o,
    input  wire logic          s_axi_bready_i,
    input  wire logic [9:0]    s_axi_araddr_i,
    input  wire logic          s_axi_arvalid_i,
    output logic               s_axi_arready_o,
    output logic [31:0]        s_axi_rdata_o,
    output logic [1:0]         s_axi_rresp_o,
    output logic               s_axi_rvalid_o,
    input  wire logic          s_axi_rready_i,
    input  wire logic [7:0]    fe_sample_i,
    input  wire logic [7:0]    te_sample_i,
    input  wire logic [7:0]    se_sample_i,
    input  wire logic [7:0]    vc_sample_i,
    input  wire logic [7:0]    rf_sample_i,
    input  wire logic [8:0]    focus_offset_i,
    input  wire logic          coef_we_i,
    input  wire logic [5:0]    coef_addr_i,
    input  wire logic [7:0]    coef_data_i,
    input  wire logic          dram_we_i,
    input  wire logic [4:0]    dram_addr_i,
    input  wire logic [15:0]   dram_data_i,
    output logic [4:0]         measure_active_o,
    output logic [7:0]         focus_input_o,
    output logic [7:0]         focus_zero_cross_o,
    output logic [7:0]         track_sled_input_o,
    output logic [7:0]         tracking_error_o,
    output logic [7:0]         rf_level_o,
    output logic [8:0]         traverse_error_o,
    output logic               focus_auto_gain_o,
    output logic               tracking_auto_gain_o,
    output logic               defect_guard_en_o,
    output logic               sled_guard_en_o,
    output logic               dac_mode_o,
    output logic [15:0]        readout_data_o,
    output logic               readout_refused_o
);

    //////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [15:0] calib;
    logic [15:0] select;
    logic        aw_held;
    logic        w_held;
    logic [9:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_calib;
    logic        wr_select;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign do_write        = aw_held && w_held && !s_axi_bvalid_o;
    assign wr_calib        = do_write && (aw_addr == ADDR_CALIB);
    assign wr_select       = do_write && (aw_addr == ADDR_SELECT);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_calib || wr_select) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            calib <= CALIB_RESET;
        end else if (wr_calib) begin
            if (w_strb[0]) begin
                calib[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                calib[15:8] <= w_data[15:8];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            select <= SELECT_RESET;
        end else if (wr_select) begin
            if (w_strb[0]) begin
                select[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                select[15:8] <= w_data[15:8];
            end
        end
    end

    // Both command words are write-only; the readout word shows live state
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            if (s_axi_araddr_i == ADDR_READOUT) begin
                s_axi_rdata_o <= {10'h000, readout_refused_o, measure_active_o,
                                  readout_data_o};
                s_axi_rresp_o <= RESP_OKAY;
            end else if (s_axi_araddr_i == ADDR_CALIB || s_axi_araddr_i == ADDR_SELECT) begin
                s_axi_rdata_o <= '0;
                s_axi_rresp_o <= RESP_OKAY;
            end else begin
                s_axi_rdata_o <= '0;
                s_axi_rresp_o <= RESP_SLVERR;
            end
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Switch outputs

    assign focus_auto_gain_o    = calib[BIT_FOCUS_AG];
    assign tracking_auto_gain_o = calib[BIT_TRACK_AG];
    assign defect_guard_en_o    = !calib[BIT_DEFECT_DIS];
    assign sled_guard_en_o      = !calib[BIT_SLED_DIS];
    assign dac_mode_o           = select[BIT_DAC_MODE];

    //////////////////////////////////////////////////////////////////////////
    // Measurement acceptance tick and measured levels

    logic [15:0] tick_count;
    logic        tick;
    logic [4:0]  meas_active;
    logic [7:0]  vc_level;
    logic [7:0]  fzero_level;
    logic [7:0]  rfzero_level;
    logic [7:0]  tzero_level;
    logic [8:0]  trav_center;

    assign tick             = (tick_count == 16'(MEASURE_CYCLES_P - 1));
    assign measure_active_o = meas_active;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || tick) begin
            tick_count <= '0;
        end else begin
            tick_count <= tick_count + 16'h0001;
        end
    end

    // Measurement switches only take effect at the interval boundary
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meas_active <= '0;
        end else if (tick) begin
            meas_active[M_VC]   <= calib[BIT_VC_MEAS];
            meas_active[M_FZ]   <= calib[BIT_FZ_MEAS];
            meas_active[M_RF]   <= calib[BIT_RF_MEAS];
            meas_active[M_TZ]   <= calib[BIT_TZ_MEAS];
            meas_active[M_TRAV] <= calib[BIT_TRAV_MEAS];
        end
    end

    logic [8:0] vc_avg;
    logic [8:0] fe_avg;
    logic [8:0] te_avg;
    logic [7:0] rf_avg;
    logic [7:0] vc_prev;
    logic [7:0] fe_prev;
    logic [7:0] te_prev;
    logic [7:0] rf_prev;
    logic [8:0] rf_sum;

    assign rf_sum = {1'b0, rf_sample_i} + {1'b0, rf_prev};

    // Averages are sums of the two latest samples, kept at nine bits; the RF average is halved to eight bits
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            vc_prev <= '0;
            fe_prev <= '0;
            te_prev <= '0;
            rf_prev <= '0;
            vc_avg  <= '0;
            fe_avg  <= '0;
            te_avg  <= '0;
            rf_avg  <= '0;
        end else begin
            vc_prev <= vc_sample_i;
            fe_prev <= fe_sample_i;
            te_prev <= te_sample_i;
            rf_prev <= rf_sample_i;
            vc_avg  <= {1'b0, vc_sample_i} + {1'b0, vc_prev};
            fe_avg  <= {1'b0, fe_sample_i} + {1'b0, fe_prev};
            te_avg  <= {1'b0, te_sample_i} + {1'b0, te_prev};
            rf_avg  <= rf_sum[8:1];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            vc_level     <= '0;
            fzero_level  <= '0;
            rfzero_level <= '0;
            tzero_level  <= '0;
            trav_center  <= '0;
        end else begin
            if (meas_active[M_VC]) begin
                vc_level <= vc_sample_i;
            end
            if (meas_active[M_FZ]) begin
                fzero_level <= fe_sample_i;
            end
            if (meas_active[M_RF]) begin
                rfzero_level <= rf_sample_i;
            end
            if (meas_active[M_TZ]) begin
                tzero_level <= te_sample_i;
            end
            if (meas_active[M_TRAV]) begin
                trav_center <= te_avg;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Compensated servo inputs

    logic [7:0] fi_vc;
    logic [7:0] fi_fz;
    logic [7:0] ts_vc;

    assign fi_vc = calib[BIT_VC_COMP_FI] ? vc_level : 8'h00;
    assign fi_fz = calib[BIT_FZ_COMP_FI] ? fzero_level : 8'h00;
    assign ts_vc = calib[BIT_VC_COMP_TS] ? vc_level : 8'h00;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            focus_input_o      <= '0;
            focus_zero_cross_o <= '0;
            track_sled_input_o <= '0;
            tracking_error_o   <= '0;
            rf_level_o         <= '0;
            traverse_error_o   <= '0;
        end else begin
            focus_input_o      <= fe_sample_i - fi_vc - fi_fz;
            focus_zero_cross_o <= calib[BIT_FZ_COMP_FZC] ? fe_sample_i - fzero_level
                                                         : fe_sample_i;
            track_sled_input_o <= se_sample_i - ts_vc;
            tracking_error_o   <= calib[BIT_TZ_COMP] ? te_sample_i - tzero_level
                                                     : te_sample_i;
            rf_level_o         <= calib[BIT_RF_COMP] ? rf_sample_i - rfzero_level
                                                     : rf_sample_i;
            traverse_error_o   <= calib[BIT_TRAV_COMP] ? te_avg - trav_center
                                                       : te_avg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Envelope tracking and readout selector

    logic [7:0]  env_peak;
    logic [7:0]  env_bottom;
    logic [7:0]  coef_ram [64];
    logic [15:0] data_ram [32];
    logic [6:0]  sel;
    logic        next_refused;
    logic [15:0] next_readout;

    assign sel = select[14:8];

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            env_peak   <= 8'h00;
            env_bottom <= 8'hff;
        end else begin
            if (rf_sample_i > env_peak) begin
                env_peak <= rf_sample_i;
            end
            if (rf_sample_i < env_bottom) begin
                env_bottom <= rf_sample_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (coef_we_i) begin
            coef_ram[coef_addr_i] <= coef_data_i;
        end
        if (dram_we_i) begin
            data_ram[dram_addr_i] <= dram_data_i;
        end
    end

    always_comb begin
        next_refused = 1'b0;
        next_readout = 16'h0000;
        if (sel >= SEL_PROT_LO && sel <= SEL_PROT_HI) begin
            next_refused = 1'b1;
        end else if (sel[6]) begin
            next_readout = {8'h00, coef_ram[sel[5:0]]};
        end else if (sel[5]) begin
            next_readout = data_ram[sel[4:0]];
        end else begin
            case (sel)
                SEL_RF_AVG:    next_readout = {8'h00, rf_avg};
                SEL_RF_LEVEL:  next_readout = {8'h00, rf_sample_i};
                SEL_FOCUS_OFS: next_readout = {7'h00, focus_offset_i};
                SEL_TRAV_CTR:  next_readout = {7'h00, trav_center};
                SEL_ENV_BOT:   next_readout = {8'h00, env_bottom};
                SEL_ENV_PEAK:  next_readout = {8'h00, env_peak};
                SEL_ENV_DIFF:  next_readout = {8'h00, env_peak - env_bottom};
                SEL_VC_AVG:    next_readout = {7'h00, vc_avg};
                SEL_FE_AVG:    next_readout = {7'h00, fe_avg};
                SEL_TE_AVG:    next_readout = {7'h00, te_avg};
                SEL_FE_IN:     next_readout = {8'h00, fe_sample_i};
                SEL_TE_IN:     next_readout = {8'h00, te_sample_i};
                SEL_SE_IN:     next_readout = {8'h00, se_sample_i};
                SEL_VC_IN:     next_readout = {8'h00, vc_sample_i};
                default:       next_readout = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            readout_data_o    <= '0;
            readout_refused_o <= 1'b0;
        end else begin
            readout_data_o    <= next_readout;
            readout_refused_o <= next_refused;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_defect_switch;
        @(posedge clock_i) disable iff (!rst_n_i)
        wr_calib && w_strb[0] |=> defect_guard_en_o == !$past(w_data[7]);
    endproperty
    a_defect_switch: assert property (p_defect_switch) else $error("defect enable wrong");

    property p_sled_switch;
        @(posedge clock_i) disable iff (!rst_n_i)
        wr_calib && w_strb[0] |=> sled_guard_en_o == !$past(w_data[6]);
    endproperty
    a_sled_switch: assert property (p_sled_switch) else $error("sled guard enable wrong");

    property p_meas_stable;
        @(posedge clock_i) disable iff (!rst_n_i)
        !tick |=> $stable(meas_active);
    endproperty
    a_meas_stable: assert property (p_meas_stable) else $error("measure changed off tick");

    property p_tick_spacing;
        @(posedge clock_i) disable iff (!rst_n_i)
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");

    property p_vc_capture;
        @(posedge clock_i) disable iff (!rst_n_i)
        meas_active[M_VC] |=> vc_level == $past(vc_sample_i);
    endproperty
    a_vc_capture: assert property (p_vc_capture) else $error("vc level not captured");

    property p_fz_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        !meas_active[M_FZ] |=> $stable(fzero_level);
    endproperty
    a_fz_hold: assert property (p_fz_hold) else $error("focus zero moved");

    property p_focus_input;
        @(posedge clock_i) disable iff (!rst_n_i)
        !calib[BIT_VC_COMP_FI] && !calib[BIT_FZ_COMP_FI] ##1 1
        |-> focus_input_o == $past(fe_sample_i);
    endproperty
    a_focus_input: assert property (p_focus_input) else $error("focus input altered");

    property p_refused;
        @(posedge clock_i) disable iff (!rst_n_i)
        sel >= SEL_PROT_LO && sel <= SEL_PROT_HI |=> readout_refused_o && readout_data_o == 16'h0000;
    endproperty
    a_refused: assert property (p_refused) else $error("protected coefficient read");

    property p_bresp_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

    property p_dac_mode;
        @(posedge clock_i) disable iff (!rst_n_i)
        wr_select && w_strb[1] |=> dac_mode_o == $past(w_data[15]);
    endproperty
    a_dac_mode: assert property (p_dac_mode) else $error("dac mode not updated");

endmodule

// ===== servo_calib_pkg.sv
package servo_calib_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CALIB   = 8'h38;
    localparam logic [7:0] IDX_SELECT  = 8'h39;
    localparam logic [7:0] IDX_READOUT = 8'h40;
    localparam int         ADDR_W      = 10;
    localparam logic [9:0] ADDR_CALIB   = {IDX_CALIB, 2'b00};
    localparam logic [9:0] ADDR_SELECT  = {IDX_SELECT, 2'b00};
    localparam logic [9:0] ADDR_READOUT = {IDX_READOUT, 2'b00};
    localparam logic [15:0] CALIB_RESET  = 16'h0000;
    localparam logic [15:0] SELECT_RESET = 16'h0000;

    // Calibration switch positions, then the DAC mode bit of the select word
    localparam int BIT_VC_MEAS     = 15;
    localparam int BIT_VC_COMP_FI  = 14;
    localparam int BIT_FZ_MEAS     = 13;
    localparam int BIT_FZ_COMP_FZC = 12;
    localparam int BIT_RF_MEAS     = 11;
    localparam int BIT_RF_COMP     = 10;
    localparam int BIT_FOCUS_AG    = 9;
    localparam int BIT_TRACK_AG    = 8;
    localparam int BIT_DEFECT_DIS  = 7;
    localparam int BIT_SLED_DIS    = 6;
    localparam int BIT_TRAV_MEAS   = 5;
    localparam int BIT_TZ_MEAS     = 4;
    localparam int BIT_FZ_COMP_FI  = 3;
    localparam int BIT_TRAV_COMP   = 2;
    localparam int BIT_TZ_COMP     = 1;
    localparam int BIT_VC_COMP_TS  = 0;
    localparam int BIT_DAC_MODE    = 15;

    // Indices into the latched measurement enables
    localparam int M_VC = 0;
    localparam int M_FZ = 1;
    localparam int M_RF = 2;
    localparam int M_TZ = 3;
    localparam int M_TRAV = 4;

    // Measurement acceptance interval
    localparam int MEASURE_INTERVAL_NS = 2900000;
    localparam int CLOCK_PERIOD_NS     = 50;
    localparam int MEASURE_CYCLES      = MEASURE_INTERVAL_NS / CLOCK_PERIOD_NS;

    // Readout select codes
    localparam logic [6:0] SEL_RF_AVG    = 7'h1f;
    localparam logic [6:0] SEL_RF_LEVEL  = 7'h1e;
    localparam logic [6:0] SEL_FOCUS_OFS = 7'h1d;
    localparam logic [6:0] SEL_TRAV_CTR  = 7'h1c;
    localparam logic [6:0] SEL_ENV_BOT   = 7'h13;
    localparam logic [6:0] SEL_ENV_PEAK  = 7'h12;
    localparam logic [6:0] SEL_ENV_DIFF  = 7'h11;
    localparam logic [6:0] SEL_VC_AVG    = 7'h0c;
    localparam logic [6:0] SEL_FE_AVG    = 7'h08;
    localparam logic [6:0] SEL_TE_AVG    = 7'h04;
    localparam logic [6:0] SEL_FE_IN     = 7'h03;
    localparam logic [6:0] SEL_TE_IN     = 7'h02;
    localparam logic [6:0] SEL_SE_IN     = 7'h01;
    localparam logic [6:0] SEL_VC_IN     = 7'h00;
    localparam logic [6:0] SEL_PROT_LO   = 7'h40;
    localparam logic [6:0] SEL_PROT_HI   = 7'h4f;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== servo_front_model.sv
module servo_front_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] level_i,
    output logic      [7:0] fe_o,
    output logic      [7:0] te_o,
    output logic      [7:0] se_o,
    output logic      [7:0] vc_o,
    output logic      [7:0] rf_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Converters settle one clock after a level change, then hold it
    always_ff @(posedge clock_i) begin
        fe_o <= level_i;
        te_o <= level_i + 8'h01;
        se_o <= level_i + 8'h02;
        vc_o <= level_i + 8'h03;
        rf_o <= level_i + 8'h04;
    end
endmodule

// ===== servo_calib_cmd_readout_select_test.sv
module servo_calib_cmd_readout_select_test;
    import servo_calib_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, coef_we = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0]  level = 8'h00, fe, te, se, vc, rf, fin, focus_zero_cross, tsi, ter, rfl;
    logic [8:0]  trv, fofs = 9'h1a5;
    logic [3:0]  wstrb = 4'h3;
    logic        awready, wready, bvalid, arready, rvalid, refused, dac, fag, tag, dg, sg;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] rd_data, rdout;
    logic [4:0]  mact;
    int          failures = 0, total_checks = 0;

    initial forever #25 clk = ~clk;

    servo_front_model front (.clock_i(clk), .level_i(level), .fe_o(fe), .te_o(te),
        .se_o(se), .vc_o(vc), .rf_o(rf));

    servo_calib_cmd_readout_select #(.MEASURE_CYCLES_P(16)) dut (
        .clock_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .fe_sample_i(fe), .te_sample_i(te), .se_sample_i(se), .vc_sample_i(vc),
        .rf_sample_i(rf), .focus_offset_i(fofs), .coef_we_i(coef_we),
        .coef_addr_i(6'h12), .coef_data_i(8'h5a), .dram_we_i(1'b0), .dram_addr_i(5'h00),
        .dram_data_i(16'h0000), .measure_active_o(mact), .focus_input_o(fin),
        .focus_zero_cross_o(focus_zero_cross), .track_sled_input_o(tsi), .tracking_error_o(ter),
        .rf_level_o(rfl), .traverse_error_o(trv), .focus_auto_gain_o(fag),
        .tracking_auto_gain_o(tag), .defect_guard_en_o(dg), .sled_guard_en_o(sg),
        .dac_mode_o(dac), .readout_data_o(rdout), .readout_refused_o(refused));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One AXI4-Lite write or read; each channel released at its own handshake
    task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
        logic aw, w, ar, done;
        done = 1'b0;
        @(posedge clk);
        if (wr) begin
            awaddr <= a;
            wdata <= {16'h0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int n = 0; n < 20 && !done; n++) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            ar = arvalid && arready;
            done = wr ? bvalid : rvalid;
            r = wr ? bresp : rresp;
            rd_data = rdata[15:0];
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (ar) arvalid <= 1'b0;
            if (done) bready <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) begin
            failures++;
            $display("MISMATCH %0t bus timeout", $time);
            final_report();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_switches();
        cmp({12'h000, dg, sg, fag, tag}, 16'h000c, "reset guards");
        bus(1'b1, ADDR_CALIB, 16'h03c0);
        repeat (2) @(posedge clk);
        cmp({12'h000, dg, sg, fag, tag}, 16'h0003, "all on");
        bus(1'b1, ADDR_CALIB, 16'h0280);
        repeat (2) @(posedge clk);
        cmp({12'h000, dg, sg, fag, tag}, 16'h0006, "mixed");
    endtask

    task automatic t_measure();
        level <= 8'h20;
        bus(1'b1, ADDR_CALIB, 16'h2000);
        repeat (40) @(posedge clk);
        cmp({11'h000, mact}, 16'h0002, "measure on");
        bus(1'b1, ADDR_CALIB, 16'h0000);
        repeat (40) @(posedge clk);
        cmp({11'h000, mact}, 16'h0000, "measure off");
        level <= 8'h50;
        bus(1'b1, ADDR_CALIB, 16'h1008);
        repeat (5) @(posedge clk);
        cmp({8'h00, focus_zero_cross}, 16'h0030, "zero cross comp");
        cmp({8'h00, fin}, 16'h0030, "focus in comp");
    endtask

    task automatic t_readout();
        coef_we <= 1'b1;
        @(posedge clk);
        coef_we <= 1'b0;
        bus(1'b1, ADDR_SELECT, 16'h0300);
        repeat (3) @(posedge clk);
        cmp(rdout, 16'h0050, "fe input");
        bus(1'b1, ADDR_SELECT, 16'h1e00);
        repeat (3) @(posedge clk);
        cmp(rdout, 16'h0054, "rf input");
        bus(1'b1, ADDR_SELECT, 16'h5200);
        repeat (3) @(posedge clk);
        cmp(rdout, 16'h005a, "coef ram");
        bus(1'b1, ADDR_SELECT, 16'hc500);
        repeat (3) @(posedge clk);
        cmp({dac, refused, rdout[13:0]}, 16'hc000, "protected");
    endtask

    // Measure four levels at one input level, then compensate at another
    task automatic t_comp();
        bus(1'b1, ADDR_CALIB, 16'h8830);
        repeat (40) @(posedge clk);
        cmp({11'h000, mact}, 16'h001d, "four measures on");
        bus(1'b1, ADDR_CALIB, 16'h4407);
        repeat (40) @(posedge clk);
        level <= 8'h60;
        repeat (5) @(posedge clk);
        cmp({8'h00, fin}, 16'h000d, "focus in vc comp");
        cmp({8'h00, focus_zero_cross}, 16'h0060, "zero cross no comp");
        cmp({8'h00, tsi}, 16'h000f, "track sled comp");
        cmp({8'h00, ter}, 16'h0010, "tracking zero comp");
        cmp({8'h00, rfl}, 16'h0010, "rf zero comp");
        cmp({7'h00, trv}, 16'h0020, "traverse comp");
        wstrb <= 4'h2;
        bus(1'b1, ADDR_SELECT, 16'h1dff);
        wstrb <= 4'h3;
        bus(1'b0, ADDR_READOUT, 16'h0000);
        cmp(rd_data, 16'h01a5, "focus offset readout");
        cmp({14'h0000, r}, {14'h0000, RESP_OKAY}, "readout response");
    endtask

    task automatic t_unmapped();
        bus(1'b1, 10'h010, 16'hffff);
        cmp({14'h0000, r}, {14'h0000, RESP_SLVERR}, "unmapped write");
        bus(1'b0, 10'h010, 16'h0000);
        cmp({r, rd_data[13:0]}, {RESP_SLVERR, 14'h0000}, "unmapped read");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_switches();
        t_measure();
        t_readout();
        t_comp();
        t_unmapped();
        final_report();
    end
endmodule
